// >>> rtl/utrb_pkg.sv
// package: register map, field positions and helpers for the serial block
package utrb_pkg;
    // ==================================================================
    // register byte addresses (one aligned 32-bit word each)
    localparam logic [4:0] OFS_DATA = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_CTRL = 5'h08;
    localparam logic [4:0] OFS_CFG = 5'h0c;
    localparam logic [4:0] OFS_DIV_LO = 5'h10;
    localparam logic [4:0] OFS_DIV_HI = 5'h14;

    // ==================================================================
    // serial_status_register bits
    localparam int ST_RXC = 7;
    localparam int ST_TXC = 6;
    localparam int ST_TXE = 5;
    localparam int ST_FE = 4;
    localparam int ST_DOR = 3;
    localparam int ST_PE = 2;
    // serial_control_register bits
    localparam int CT_TXCIE = 6;
    localparam int CT_TXEIE = 5;
    localparam int CT_RXEN = 4;
    localparam int CT_TXEN = 3;
    localparam int CT_RX9 = 1;
    localparam int CT_TX9 = 0;
    // configuration register bits
    localparam int CF_SYNC = 6;
    localparam int CF_PAR_EN = 5;
    localparam int CF_PAR_ODD = 4;
    localparam int CF_STOP2 = 3;
    localparam int CF_CSZ_LSB = 0;
    localparam int CSZ_W = 3;

    // ==================================================================
    // reset values and encodings
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h03;
    localparam logic [15:0] DIV_RST = 16'h0019;
    localparam logic [2:0] CSZ_9 = 3'h7;
    localparam logic [3:0] BITS_MIN = 4'h5;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_9 = 4'h9;
    localparam logic [2:0] CSZ_MAX_NARROW = 3'h3;
    localparam int RX_DEPTH = 2;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR,
        TX_STOP1, TX_STOP2} utrb_tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR,
        RX_STOP} utrb_rx_state_t;

    // ==================================================================
    // number of data bits for a char_size_field code
    function automatic logic [3:0] char_bits(input logic [2:0] csz);
        if (csz == CSZ_9)
            return BITS_9;
        else if (csz <= CSZ_MAX_NARROW)
            return BITS_MIN + {1'b0, csz};
        else
            return BITS_8;
    endfunction

    // clear the bits above the character width
    function automatic logic [8:0] mask_data(input logic [8:0] d,
                                             input logic [2:0] csz);
        logic [8:0] m;
        m = 9'h1ff >> (BITS_9 - char_bits(csz));
        return d & m;
    endfunction

    // xor of the used data bits, inverted for odd parity
    function automatic logic parity(input logic [8:0] d,
                                    input logic [2:0] csz,
                                    input logic odd);
        return (^mask_data(d, csz)) ^ odd;
    endfunction
endpackage

// >>> rtl/utrb_bitclk.sv
// bit-rate tick source: baud divider or rising edge of the transfer clock
`timescale 1ns/1ps
`default_nettype none
module utrb_bitclk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic restart_i,
    input wire logic [15:0] div_i,
    input wire logic sync_i,
    input wire logic xck_i,
    // tick out
    output logic tick_o
);
    typedef struct packed {
        logic [15:0] cnt;
        logic xck_prev;
        logic tick;
    } utrb_bitclk_state_t;

    utrb_bitclk_state_t state_reg;
    utrb_bitclk_state_t state_next;

    // ==================================================================
    // next state: restart lands the first tick half a bit later
    always_comb begin
        state_next = state_reg;
        state_next.xck_prev = xck_i;
        state_next.tick = 1'b0;
        if (sync_i) begin
            state_next.tick = xck_i & ~state_reg.xck_prev;
        end else if (restart_i) begin
            state_next.cnt = div_i >> 1;
        end else if (state_reg.cnt == 16'h0000) begin
            state_next.cnt = div_i;
            state_next.tick = 1'b1;
        end else begin
            state_next.cnt = state_reg.cnt - 16'h0001;
        end
    end

    // ==================================================================
    always_ff @(posedge clk_i) begin
        if (rst_i)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign tick_o = state_reg.tick;
endmodule
`default_nettype wire

// >>> rtl/utrb_top.sv
// serial transmitter and receiver with buffers, flags and register slave
// Notes on behaviour
// - two transmit flags, each with own request
// - buffer-empty set until buffer holds unsent data
// - buffer-empty request held while enabled and set
// - data write loads buffer, clears buffer-empty
// - complete flag sets when frame out, buffer empty
// - complete clears on service or written one
// - complete request raised when enabled and set
// - parity bit after last data bit if enabled
// - transmit disable waits for frames to finish
// - disabled transmitter releases the line pin
// - receive enable takes over the receive pin
// - synchronous mode samples on transfer clock
// - start bit begins reception, bits shifted in
// - second stop bit ignored by receiver
// - first stop bit moves frame to buffer
// - unused upper data bits read zero
// - ninth bit and errors stored per entry
// - start, data lsb first, parity, stop
// - receive-complete set while buffer holds data
// - two-entry buffer, overrun on fourth start
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module utrb_top (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    // avalon-mm slave
    input wire logic [4:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // serial line
    output logic TX_LINE_O,
    output logic TX_LINE_OE_O,
    input wire logic RX_LINE_I,
    output logic RX_OWN_O,
    input wire logic XFER_CLK_I,
    // interrupt requests
    output logic TXE_IRQ_O,
    output logic TXC_IRQ_O,
    input wire logic TXC_IRQ_ACK_I
);
    typedef struct packed {
        // bus
        logic wait_q;
        logic [7:0] rdata;
        // control and configuration
        logic txcie, txeie, rxen, txen, tx9;
        logic [2:0] csz;
        logic par_en, par_odd, stop2, sync;
        logic [15:0] div;
        // transmitter
        logic [8:0] tbuf;
        logic tbuf_v;
        logic [8:0] tsh;
        utrb_pkg::utrb_tx_state_t tst;
        logic [3:0] tcnt;
        logic tpar, txc, tx_pin, tx_oe, txe_irq, txc_irq;
        // receiver
        utrb_pkg::utrb_rx_state_t rst;
        logic [8:0] rsh;
        logic [3:0] rcnt;
        logic rpar;
        logic [1:0][8:0] fd;
        logic [1:0] ffe, fpe, fdor;
        logic rd_ptr;
        logic [1:0] fcnt;
        logic pend_v, pend_fe, pend_pe, dor_pend;
        logic [8:0] pend_d;
    } utrb_state_t;

    utrb_state_t state_reg;
    utrb_state_t state_next;
    logic tx_tick, rx_tick, rx_restart;

    // ==================================================================
    // bit-rate ticks, the receive one realigned on each start edge in asynchronous mode
    utrb_bitclk u_tx_clk (
        .clk_i(SYS_CLK_I),
        .rst_i(SYS_RST_I),
        .restart_i(1'b0),
        .div_i(state_reg.div),
        .sync_i(state_reg.sync),
        .xck_i(XFER_CLK_I),
        .tick_o(tx_tick)
    );
    utrb_bitclk u_rx_clk (
        .clk_i(SYS_CLK_I),
        .rst_i(SYS_RST_I),
        .restart_i(rx_restart),
        .div_i(state_reg.div),
        .sync_i(state_reg.sync),
        .xck_i(XFER_CLK_I),
        .tick_o(rx_tick)
    );

    assign rx_restart = state_reg.rxen && state_reg.rst == utrb_pkg::RX_IDLE
                        && !RX_LINE_I;

    // ==================================================================
    // next-state logic
    always_comb begin
        logic req, wr, rd, load, fin, push_v, push_fe, push_pe, head_ok;
        logic frm_fe, frm_pe;
        logic [8:0] push_d, frm_d, head_d;
        logic [7:0] rv, wd;
        logic [3:0] nb;
        logic widx;
        state_next = state_reg;
        req = AVS_READ_I | AVS_WRITE_I;
        wr = AVS_WRITE_I && !state_reg.wait_q;
        rd = AVS_READ_I && !state_reg.wait_q;
        wd = AVS_WRITEDATA_I[7:0];
        nb = utrb_pkg::char_bits(state_reg.csz);
        head_ok = state_reg.fcnt != 2'h0;
        head_d = state_reg.fd[state_reg.rd_ptr];
        load = 1'b0;
        fin = 1'b0;
        push_v = 1'b0;
        push_d = '0;
        push_fe = 1'b0;
        push_pe = 1'b0;
        frm_d = '0;
        frm_fe = 1'b0;
        frm_pe = 1'b0;
        widx = 1'b0;
        rv = '0;

        // read mux, sampled in the first cycle of the request
        case (AVS_ADDRESS_I)
            utrb_pkg::OFS_DATA: begin
                if (head_ok)
                    rv = 8'(utrb_pkg::mask_data(head_d,
                        state_reg.csz));
            end
            utrb_pkg::OFS_STATUS: begin
                rv[utrb_pkg::ST_RXC] = head_ok;
                rv[utrb_pkg::ST_TXC] = state_reg.txc;
                rv[utrb_pkg::ST_TXE] = !state_reg.tbuf_v;
                rv[utrb_pkg::ST_FE] = head_ok
                    && state_reg.ffe[state_reg.rd_ptr];
                rv[utrb_pkg::ST_DOR] = head_ok
                    && state_reg.fdor[state_reg.rd_ptr];
                rv[utrb_pkg::ST_PE] = head_ok
                    && state_reg.fpe[state_reg.rd_ptr];
            end
            utrb_pkg::OFS_CTRL: begin
                rv[utrb_pkg::CT_TXCIE] = state_reg.txcie;
                rv[utrb_pkg::CT_TXEIE] = state_reg.txeie;
                rv[utrb_pkg::CT_RXEN] = state_reg.rxen;
                rv[utrb_pkg::CT_TXEN] = state_reg.txen;
                rv[utrb_pkg::CT_RX9] = head_ok && head_d[8];
                rv[utrb_pkg::CT_TX9] = state_reg.tx9;
            end
            utrb_pkg::OFS_CFG: begin
                rv[utrb_pkg::CF_SYNC] = state_reg.sync;
                rv[utrb_pkg::CF_PAR_EN] = state_reg.par_en;
                rv[utrb_pkg::CF_PAR_ODD] = state_reg.par_odd;
                rv[utrb_pkg::CF_STOP2] = state_reg.stop2;
                rv[utrb_pkg::CF_CSZ_LSB +: utrb_pkg::CSZ_W] = state_reg.csz;
            end
            utrb_pkg::OFS_DIV_LO: rv = state_reg.div[7:0];
            utrb_pkg::OFS_DIV_HI: rv = state_reg.div[15:8];
            default: rv = '0;
        endcase

        // one wait cycle, then the request completes
        state_next.wait_q = !(req && state_reg.wait_q);
        if (req && state_reg.wait_q)
            state_next.rdata = rv;

        // register writes take effect at the completing edge
        if (wr) begin
            case (AVS_ADDRESS_I)
                utrb_pkg::OFS_DATA: begin
                    state_next.tbuf = {state_reg.tx9, wd};
                    state_next.tbuf_v = 1'b1;
                end
                utrb_pkg::OFS_STATUS: begin
                    // only the complete flag is writable, others ignored
                    if (wd[utrb_pkg::ST_TXC])
                        state_next.txc = 1'b0;
                end
                utrb_pkg::OFS_CTRL: begin
                    state_next.txcie = wd[utrb_pkg::CT_TXCIE];
                    state_next.txeie = wd[utrb_pkg::CT_TXEIE];
                    state_next.rxen = wd[utrb_pkg::CT_RXEN];
                    state_next.txen = wd[utrb_pkg::CT_TXEN];
                    state_next.tx9 = wd[utrb_pkg::CT_TX9];
                end
                utrb_pkg::OFS_CFG: begin
                    state_next.sync = wd[utrb_pkg::CF_SYNC];
                    state_next.par_en = wd[utrb_pkg::CF_PAR_EN];
                    state_next.par_odd = wd[utrb_pkg::CF_PAR_ODD];
                    state_next.stop2 = wd[utrb_pkg::CF_STOP2];
                    state_next.csz = wd[utrb_pkg::CF_CSZ_LSB +:
                                        utrb_pkg::CSZ_W];
                end
                utrb_pkg::OFS_DIV_LO: state_next.div[7:0] = wd;
                utrb_pkg::OFS_DIV_HI: state_next.div[15:8] = wd;
                default: ;
            endcase
        end
        if (TXC_IRQ_ACK_I)
            state_next.txc = 1'b0;

        // transmit frame sequencer, one bit per tick
        if (tx_tick) begin
            case (state_reg.tst)
                utrb_pkg::TX_IDLE: load = state_reg.tbuf_v;
                utrb_pkg::TX_START, utrb_pkg::TX_DATA: begin
                    if (state_reg.tcnt == nb) begin
                        if (state_reg.par_en) begin
                            state_next.tx_pin = state_reg.tpar;
                            state_next.tst = utrb_pkg::TX_PAR;
                        end else begin
                            state_next.tx_pin = 1'b1;
                            state_next.tst = utrb_pkg::TX_STOP1;
                        end
                    end else begin
                        state_next.tx_pin = state_reg.tsh[0];
                        state_next.tsh = state_reg.tsh >> 1;
                        state_next.tcnt = state_reg.tcnt + 4'h1;
                        state_next.tst = utrb_pkg::TX_DATA;
                    end
                end
                utrb_pkg::TX_PAR: begin
                    state_next.tx_pin = 1'b1;
                    state_next.tst = utrb_pkg::TX_STOP1;
                end
                utrb_pkg::TX_STOP1: begin
                    if (state_reg.stop2)
                        state_next.tst = utrb_pkg::TX_STOP2;
                    else
                        fin = 1'b1;
                end
                utrb_pkg::TX_STOP2: fin = 1'b1;
                default: state_next.tst = utrb_pkg::TX_IDLE;
            endcase
        end
        // next frame follows the last stop bit with no idle gap
        if (fin) begin
            state_next.tst = utrb_pkg::TX_IDLE;
            state_next.tx_pin = 1'b1;
            load = state_reg.tbuf_v;
            if (!state_reg.tbuf_v)
                state_next.txc = 1'b1;
        end
        if (load) begin
            state_next.tsh = state_reg.tbuf;
            state_next.tbuf_v = wr && AVS_ADDRESS_I == utrb_pkg::OFS_DATA;
            state_next.tpar = utrb_pkg::parity(state_reg.tbuf,
                state_reg.csz, state_reg.par_odd);
            state_next.tcnt = 4'h0;
            state_next.tx_pin = 1'b0;
            state_next.tst = utrb_pkg::TX_START;
        end
        // pin stays owned until shift register and buffer are empty
        state_next.tx_oe = state_reg.txen || state_next.tbuf_v
            || state_next.tst != utrb_pkg::TX_IDLE;
        state_next.txe_irq = state_reg.txeie && !state_next.tbuf_v;
        state_next.txc_irq = state_reg.txcie && state_next.txc;

        // pop the head entry on a completed data read
        if (rd && AVS_ADDRESS_I == utrb_pkg::OFS_DATA && head_ok) begin
            state_next.fcnt = state_reg.fcnt - 2'h1;
            state_next.rd_ptr = !state_reg.rd_ptr;
        end

        // receive frame sequencer
        case (state_reg.rst)
            utrb_pkg::RX_IDLE: begin
                if (rx_restart)
                    state_next.rst = utrb_pkg::RX_START;
            end
            utrb_pkg::RX_START: begin
                if (rx_tick) begin
                    if (RX_LINE_I) begin
                        state_next.rst = utrb_pkg::RX_IDLE;
                    end else begin
                        state_next.rst = utrb_pkg::RX_DATA;
                        state_next.rcnt = 4'h0;
                        if (state_reg.pend_v
                            && state_reg.fcnt == 2'(utrb_pkg::RX_DEPTH))
                            state_next.dor_pend = 1'b1;
                    end
                end
            end
            utrb_pkg::RX_DATA: begin
                if (rx_tick) begin
                    state_next.rsh = {RX_LINE_I, state_reg.rsh[8:1]};
                    state_next.rcnt = state_reg.rcnt + 4'h1;
                    if (state_reg.rcnt + 4'h1 == nb)
                        state_next.rst = state_reg.par_en ?
                            utrb_pkg::RX_PAR : utrb_pkg::RX_STOP;
                end
            end
            utrb_pkg::RX_PAR: begin
                if (rx_tick) begin
                    state_next.rpar = RX_LINE_I;
                    state_next.rst = utrb_pkg::RX_STOP;
                end
            end
            utrb_pkg::RX_STOP: begin
                // frame ends at the first stop bit
                if (rx_tick) begin
                    state_next.rst = utrb_pkg::RX_IDLE;
                    frm_d = state_reg.rsh >> (utrb_pkg::BITS_9 - nb);
                    frm_fe = !RX_LINE_I;
                    frm_pe = state_reg.par_en && state_reg.rpar !=
                        utrb_pkg::parity(frm_d, state_reg.csz,
                                         state_reg.par_odd);
                    // a full buffer parks the frame; a fourth is lost
                    if (state_reg.pend_v) begin
                        state_next.pend_v = 1'b1;
                    end else if (state_next.fcnt ==
                                 2'(utrb_pkg::RX_DEPTH)) begin
                        state_next.pend_v = 1'b1;
                        state_next.pend_d = frm_d;
                        state_next.pend_fe = frm_fe;
                        state_next.pend_pe = frm_pe;
                    end else begin
                        push_v = 1'b1;
                        push_d = frm_d;
                        push_fe = frm_fe;
                        push_pe = frm_pe;
                    end
                end
            end
            default: state_next.rst = utrb_pkg::RX_IDLE;
        endcase
        // parked frame moves in once an entry frees up
        if (state_reg.pend_v && state_next.fcnt !=
            2'(utrb_pkg::RX_DEPTH)) begin
            push_v = 1'b1;
            push_d = state_reg.pend_d;
            push_fe = state_reg.pend_fe;
            push_pe = state_reg.pend_pe;
            state_next.pend_v = 1'b0;
        end
        if (push_v) begin
            widx = state_next.rd_ptr ^ state_next.fcnt[0];
            state_next.fd[widx] = push_d;
            state_next.ffe[widx] = push_fe;
            state_next.fpe[widx] = push_pe;
            state_next.fdor[widx] = state_next.dor_pend;
            state_next.dor_pend = 1'b0;
            state_next.fcnt = state_next.fcnt + 2'h1;
        end
        // disabling the receiver is immediate and flushes the buffer
        if (!state_reg.rxen) begin
            state_next.rst = utrb_pkg::RX_IDLE;
            state_next.fcnt = 2'h0;
            state_next.pend_v = 1'b0;
            state_next.dor_pend = 1'b0;
        end
    end

    // ==================================================================
    // state register
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            state_reg <= '0;
            state_reg.wait_q <= 1'b1;
            state_reg.tx_pin <= 1'b1;
            state_reg.csz <= utrb_pkg::CFG_RST[utrb_pkg::CF_CSZ_LSB +:
                                               utrb_pkg::CSZ_W];
            state_reg.div <= utrb_pkg::DIV_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==================================================================
    // outputs, all straight from the state register
    assign AVS_READDATA_O = {24'h000000, state_reg.rdata};
    assign AVS_WAITREQUEST_O = state_reg.wait_q;
    assign TX_LINE_O = state_reg.tx_pin;
    assign TX_LINE_OE_O = state_reg.tx_oe;
    assign RX_OWN_O = state_reg.rxen;
    assign TXE_IRQ_O = state_reg.txe_irq;
    assign TXC_IRQ_O = state_reg.txc_irq;
endmodule
`default_nettype wire

// >>> dv/utrb_properties.sv
// checker: line, ownership and request relations at the block's ports
`timescale 1ns/1ps
`default_nettype none
module utrb_properties (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    // register bus
    input wire logic [4:0] AVS_ADDRESS_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic AVS_WAITREQUEST_O,
    // line and requests
    input wire logic TX_LINE_O,
    input wire logic TX_LINE_OE_O,
    input wire logic RX_OWN_O,
    input wire logic TXE_IRQ_O,
    input wire logic TXC_IRQ_O
);
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);
    // control write completing at this edge
    logic ctl_wr;
    assign ctl_wr = AVS_WRITE_I && !AVS_WAITREQUEST_O &&
        AVS_ADDRESS_I == utrb_pkg::OFS_CTRL;
    // released or idle line must read high
    a_tx_idle: assert property (!TX_LINE_OE_O |-> TX_LINE_O)
        else $error("line low while not owned");
    a_start_owned: assert property ($fell(TX_LINE_O) |-> TX_LINE_OE_O)
        else $error("start bit on a released pin");
    // a frame in flight keeps the pin even after disable
    a_oe_hold: assert property (TX_LINE_OE_O && !TX_LINE_O |=> TX_LINE_OE_O)
        else $error("pin released mid-frame");
    // ownership follows the control byte one edge on and masks two; checked two edges on
    a_rx_own: assert property (ctl_wr |-> ##2
        RX_OWN_O == $past(AVS_WRITEDATA_I[utrb_pkg::CT_RXEN], 2))
        else $error("receive ownership wrong");
    a_txe_mask: assert property (ctl_wr &&
        !AVS_WRITEDATA_I[utrb_pkg::CT_TXEIE] |-> ##2 !TXE_IRQ_O)
        else $error("empty request not masked");
    a_txc_mask: assert property (ctl_wr &&
        !AVS_WRITEDATA_I[utrb_pkg::CT_TXCIE] |-> ##2 !TXC_IRQ_O)
        else $error("complete request not masked");
    // a fresh complete request comes only with the line idle
    a_txc_idle: assert property ($rose(TXC_IRQ_O) &&
        !$past(ctl_wr, 2) |-> TX_LINE_O) else $error("complete mid-frame");
    a_reset_vals: assert property (disable iff (1'b0) SYS_RST_I |=>
        TX_LINE_O && !TX_LINE_OE_O && !RX_OWN_O && !TXE_IRQ_O && !TXC_IRQ_O)
        else $error("outputs not at reset level");
endmodule
`default_nettype wire

// >>> dv/utrb_remote.sv
// remote serial device: sends frames on rx, captures frames from tx
`timescale 1ns/1ps
`default_nettype none
module utrb_remote #(parameter int BIT = 4) (
    // clock and serial lines
    input wire logic clk_i,
    input wire logic tx_i,
    output logic rx_o,
    // the ten bits after the start bit: data bits, then the bits that follow them
    output logic [9:0] got_o
);
    // start low, data lsb first, stop high; idle stays high
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_o <= f[i];
            repeat (BIT) @(posedge clk_i);
        end
    endtask
    // sample mid-bit, timed from the falling start edge
    initial begin
        rx_o = 1'b1;
        forever begin
            @(negedge tx_i);
            repeat (BIT / 2) @(posedge clk_i);
            for (int i = 0; i < 10; i++) begin
                repeat (BIT) @(posedge clk_i);
                got_o[i] = tx_i;
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/utrb_top_bench.sv
// bench: frames both ways, flags, requests and transmitter release
`timescale 1ns/1ps
`default_nettype none
module utrb_top_bench;
    typedef struct {logic [7:0] d; logic [7:0] cfg; logic [9:0] f;} utrb_row_t;
    // data, format, and the ten bits seen after the start bit
    utrb_row_t rows [4] = '{'{8'ha5, 8'h03, 10'h3a5}, '{8'h01, 8'h23, 10'h301},
        '{8'h3c, 8'h33, 10'h33c}, '{8'h00, 8'h0b, 10'h300}};
    logic clk = 0, rst = 1, rd = 0, wr = 0, ack = 0;
    logic rx, txd, oe, own, txe, txc, wt;
    logic [4:0] adr = '0;
    logic [1:0] xc = '0;
    logic [31:0] wd = '0, rdat, q;
    logic [9:0] got;
    int num_errors = 0, num_checks = 0;
    initial forever #10 clk = ~clk;
    // transfer clock, one bit per four system clocks
    always @(posedge clk) xc <= xc + 2'h1;
    utrb_top i_dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(adr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
        .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wt), .TX_LINE_O(txd),
        .TX_LINE_OE_O(oe), .RX_LINE_I(rx), .RX_OWN_O(own), .XFER_CLK_I(xc[1]),
        .TXE_IRQ_O(txe), .TXC_IRQ_O(txc), .TXC_IRQ_ACK_I(ack));
    // a released transmit pin is pulled high at the far side
    utrb_remote #(.BIT(4)) i_remote (.clk_i(clk), .tx_i(oe ? txd : 1'b1),
        .rx_o(rx), .got_o(got));
    // one bus cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wt !== 1'b0)
            @(posedge clk);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // poll status until a flag bit is up, bounded
    task automatic wait_st(input int b);
        q = '0;
        for (int n = 0; n < 100 && q[b] !== 1'b1; n++)
            bus(0, utrb_pkg::OFS_STATUS, 0);
        chk("flag", q[b], 1'b1);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // watchdog far beyond the run's length
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(0, utrb_pkg::OFS_STATUS, 0);
        chk("status", q, 32'h20);
        bus(0, 5'h18, 0);
        chk("unmapped", q, 0);
        bus(1, utrb_pkg::OFS_DIV_LO, 3);
        bus(1, utrb_pkg::OFS_CTRL, 32'h18);
        // one frame out and one frame in for each row
        foreach (rows[i]) begin
            bus(1, utrb_pkg::OFS_CFG, rows[i].cfg);
            bus(1, utrb_pkg::OFS_DATA, rows[i].d);
            wait_st(6);
            chk("tx complete", q[6], 1'b1);
            repeat (8) @(posedge clk);
            chk("frame", got, rows[i].f);
            i_remote.send(rows[i].d);
            wait_st(7);
            bus(0, utrb_pkg::OFS_DATA, 0);
            chk("rx data", q, rows[i].d);
            bus(1, utrb_pkg::OFS_STATUS, 32'h40);
            bus(0, utrb_pkg::OFS_STATUS, 0);
            chk("flags cleared", q[7:6], 2'b00);
        end
        // five-bit characters come back with the upper bits zero
        bus(1, utrb_pkg::OFS_CFG, 0);
        i_remote.send(8'hff);
        wait_st(7);
        bus(0, utrb_pkg::OFS_DATA, 0);
        chk("short char", q, 32'h1f);
        // nine bits on the transfer clock
        bus(1, utrb_pkg::OFS_CFG, 8'h47);
        bus(1, utrb_pkg::OFS_DATA, 8'h96);
        wait_st(6);
        repeat (8) @(posedge clk);
        chk("sync", got, 10'h296);
        bus(1, utrb_pkg::OFS_STATUS, 32'h40);
        // both requests enabled, complete serviced by acknowledge
        bus(1, utrb_pkg::OFS_CFG, 3);
        bus(1, utrb_pkg::OFS_CTRL, 32'h78);
        repeat (2) @(posedge clk);
        chk("empty request", txe, 1'b1);
        bus(1, utrb_pkg::OFS_DATA, 8'h55);
        wait_st(6);
        repeat (2) @(posedge clk);
        chk("complete request", txc, 1'b1);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        repeat (3) @(posedge clk);
        chk("complete serviced", txc, 1'b0);
        // disable with one frame out and one waiting in the buffer
        bus(1, utrb_pkg::OFS_DATA, 8'h81);
        repeat (5) @(posedge clk);
        bus(1, utrb_pkg::OFS_DATA, 8'h7e);
        bus(1, utrb_pkg::OFS_CTRL, 32'h10);
        repeat (50) @(posedge clk);
        chk("still owned", {oe, own}, 2'b11);
        repeat (60) @(posedge clk);
        chk("released", {oe, txd}, 2'b01);
        bus(1, utrb_pkg::OFS_CTRL, 0);
        // mid-run reset
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(0, utrb_pkg::OFS_STATUS, 0);
        chk("reset", q, 32'h20);
        test_done();
    end
endmodule
bind utrb_top utrb_properties i_props (.*);
`default_nettype wire
